// File: common/report_pkg.sv
// Constants for the counter interrupt and diagnostic reporting block
package report_pkg;
  localparam int          NUM_CH       = 8;
  localparam int          REC_BYTES    = 16;
  localparam int          ADDR_W       = 12;
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_MODE     = 12'h004;
  localparam logic [11:0] OFS_EVT_EN   = 12'h008;
  localparam logic [11:0] OFS_EVT_DATA = 12'h00C;
  localparam logic [11:0] OFS_GROUP    = 12'h010;
  localparam logic [11:0] OFS_STATUS   = 12'h014;
  localparam logic [11:0] OFS_MASK     = 12'h018;
  localparam logic [11:0] OFS_REC_BASE = 12'h020;
  localparam logic [11:0] OFS_REC_LAST = 12'h02C;
  localparam int          CTRL_PROC_EN = 0;
  localparam int          CTRL_DIAG_EN = 1;
  localparam int          ST_PROC      = 0;
  localparam int          ST_DIAG      = 1;
  localparam int          ST_LOST      = 2;
  localparam int          ST_W         = 3;
  localparam int          B0_MOD_FAIL  = 0;
  localparam int          B0_INT_ERR   = 1;
  localparam int          B0_EXT_ERR   = 2;
  localparam int          B0_CH_SUM    = 3;
  localparam int          B0_NO_PARAM  = 6;
  localparam int          B0_BAD_PARAM = 7;
  localparam int          BYTE_WDOG    = 2;
  localparam int          B2_WDOG      = 3;
  localparam int          BYTE_LOST    = 3;
  localparam int          B3_LOST      = 6;
  localparam int          BYTE_CH_ERR  = 7;
  localparam int          BYTE_SINGLE0 = 8;
  localparam int          SINGLE_LO    = 4;
  localparam int          SINGLE_HI    = 6;
  localparam int          NIB_OPEN     = 0;
  localparam int          NIB_CLOSE    = 1;
  localparam int          NIB_WRAP     = 2;
  localparam int          NIB_LIMIT    = 3;
  localparam logic [2:0]  HSIZE_WORD   = 3'h2;
  localparam logic [1:0]  HRESP_OKAY   = 2'h0;
  localparam logic [2:0]  STATUS_RST   = 3'h0;
  localparam logic [1:0]  CTRL_RST     = 2'h0;
endpackage : report_pkg

// File: common/report_if.sv
// Interface between the reporting core, the event packer and the record builder
`timescale 1ns/1ps
`default_nettype none
interface report_if;
  logic [31:0]  event_word;
  logic         event_any;
  logic [127:0] record;
  logic         lost_flag;
  modport packer  (output event_word, output event_any);
  modport builder (input lost_flag, output record);
  modport core    (input event_word, input event_any, input record, output lost_flag);
endinterface : report_if
`default_nettype wire

// File: rtl/event_packer.sv
// Packs per-channel events into the four byte event word
`timescale 1ns/1ps
`default_nettype none
module event_packer
  import report_pkg::*;
#(
  parameter int NCH = report_pkg::NUM_CH
) (
  input  wire logic [NCH-1:0]   gate_open,
  input  wire logic [NCH-1:0]   gate_close,
  input  wire logic [NCH-1:0]   count_wrap,
  input  wire logic [NCH-1:0]   compare_hit,
  input  wire logic [NCH-1:0]   measure_done,
  input  wire logic [NCH-1:0]   limit_exceeded,
  input  wire logic [NCH-1:0]   freq_mode,
  input  wire logic [4*NCH-1:0] nibble_enable,
  report_if.packer              rif
);
  function automatic logic [3:0] pack_nibble(input logic op, input logic cl, input logic wr,
                                             input logic cm, input logic dn, input logic lm,
                                             input logic fm);
    logic [3:0] n;
    n            = 4'h0;
    n[NIB_OPEN]  = op;
    n[NIB_CLOSE] = cl;
    n[NIB_WRAP]  = fm ? dn : wr;
    n[NIB_LIMIT] = fm ? lm : cm;
    return n;
  endfunction : pack_nibble

  logic [4*NCH-1:0] word;

  always_comb begin
    word = '0;
    for (int ch = 0; ch < NCH; ch++) begin
      word[4*ch +: 4] = pack_nibble(gate_open[ch], gate_close[ch], count_wrap[ch],
                                    compare_hit[ch], measure_done[ch], limit_exceeded[ch],
                                    freq_mode[ch]);
    end
  end

  assign rif.event_word = 32'(word & nibble_enable);
  assign rif.event_any  = |(word & nibble_enable);
endmodule : event_packer
`default_nettype wire

// File: rtl/diag_builder.sv
// Assembles the sixteen byte diagnostic record from live fault levels
`timescale 1ns/1ps
`default_nettype none
module diag_builder
  import report_pkg::*;
#(
  parameter int NCH = report_pkg::NUM_CH
) (
  input  wire logic             module_failed_flag,
  input  wire logic             internal_error,
  input  wire logic             external_error_flag,
  input  wire logic             params_missing,
  input  wire logic             params_incorrect,
  input  wire logic             watchdog_trip_flag,
  input  wire logic [NCH-1:0]   channel_error,
  input  wire logic [2*NCH-1:0] single_error,
  report_if.builder             rif
);
  logic [8*REC_BYTES-1:0] rec;

  always_comb begin
    rec                                = '0;
    rec[B0_MOD_FAIL]                   = module_failed_flag;
    rec[B0_INT_ERR]                    = internal_error;
    rec[B0_EXT_ERR]                    = external_error_flag;
    rec[B0_CH_SUM]                     = |channel_error;
    rec[B0_NO_PARAM]                   = params_missing;
    rec[B0_BAD_PARAM]                  = params_incorrect;
    rec[8*BYTE_WDOG + B2_WDOG]         = watchdog_trip_flag;
    rec[8*BYTE_LOST + B3_LOST]         = rif.lost_flag;
    for (int ch = 0; ch < NCH; ch++) begin
      rec[8*BYTE_CH_ERR + ch]                  = channel_error[ch];
      rec[8*(BYTE_SINGLE0 + ch) + SINGLE_LO]   = single_error[2*ch];
      rec[8*(BYTE_SINGLE0 + ch) + SINGLE_HI]   = single_error[2*ch+1];
    end
  end

  assign rif.record = rec;
endmodule : diag_builder
`default_nettype wire

// File: rtl/counter_interrupt_reporting.sv
// AHB-Lite reporting core with process and diagnostic interrupts
`timescale 1ns/1ps
`default_nettype none
module counter_interrupt_reporting
  import report_pkg::*;
#(
  parameter int NCH = report_pkg::NUM_CH
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic [1:0]             hresp,
  output logic                   irq,
  output logic                   process_irq,
  output logic                   diag_irq,
  input  wire logic [NCH-1:0]    gate_open,
  input  wire logic [NCH-1:0]    gate_close,
  input  wire logic [NCH-1:0]    count_wrap,
  input  wire logic [NCH-1:0]    compare_hit,
  input  wire logic [NCH-1:0]    measure_done,
  input  wire logic [NCH-1:0]    limit_exceeded,
  input  wire logic              module_failed_flag,
  input  wire logic              internal_error,
  input  wire logic              external_error_flag,
  input  wire logic              params_missing,
  input  wire logic              params_incorrect,
  input  wire logic              watchdog_trip_flag,
  input  wire logic [NCH-1:0]    channel_error,
  input  wire logic [2*NCH-1:0]  single_error
);
  import report_pkg::*;

  report_if rif ();

  // Registers
  logic [1:0]         ctrl_ff;
  logic [NCH-1:0]     mode_ff;
  logic [4*NCH-1:0]   evt_en_ff;
  logic [31:0]        event_data_ff;
  logic [ST_W-1:0]    status_ff;
  logic [ST_W-1:0]    mask_ff;
  logic [127:0]       prev_rec_ff;
  logic [127:0]       snap_rec_ff;
  logic [31:0]        hrdata_ff;

  // Bus data phase tracking
  logic               wr_pend_ff;
  logic [ADDR_W-1:0]  wr_addr_ff;

  // Combinational terms
  logic               addr_valid;
  logic               wr_hit;
  logic [ST_W-1:0]    st_clr;
  logic [ST_W-1:0]    st_set;
  logic [ST_W-1:0]    nxt_status;
  logic [31:0]        nxt_rdata;
  logic               event_take;
  logic               slot_free;
  logic               diag_hit;
  logic [ADDR_W-1:0]  rd_addr;

  event_packer #(
    .NCH            (NCH)
  ) u_packer (
    .gate_open      (gate_open),
    .gate_close     (gate_close),
    .count_wrap     (count_wrap),
    .compare_hit    (compare_hit),
    .measure_done   (measure_done),
    .limit_exceeded (limit_exceeded),
    .freq_mode      (mode_ff),
    .nibble_enable  (evt_en_ff),
    .rif            (rif.packer)
  );

  diag_builder #(
    .NCH                 (NCH)
  ) u_builder (
    .module_failed_flag  (module_failed_flag),
    .internal_error      (internal_error),
    .external_error_flag (external_error_flag),
    .params_missing      (params_missing),
    .params_incorrect    (params_incorrect),
    .watchdog_trip_flag  (watchdog_trip_flag),
    .channel_error       (channel_error),
    .single_error        (single_error),
    .rif                 (rif.builder)
  );

  // Lost flag feeds back into the record
  assign rif.lost_flag = status_ff[ST_LOST];

  // Address phase decode
  assign addr_valid = hsel & htrans[1] & hready;
  assign rd_addr    = haddr[ADDR_W-1:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else if (hready) begin
      wr_pend_ff <= addr_valid & hwrite & (hsize == HSIZE_WORD);
      wr_addr_ff <= haddr[ADDR_W-1:0];
    end
  end

  // Writes land at the end of the data phase
  assign wr_hit = wr_pend_ff;

  function automatic logic reg_write(input logic [ADDR_W-1:0] ofs);
    return wr_hit && (wr_addr_ff == ofs);
  endfunction : reg_write

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= CTRL_RST;
    end else if (reg_write(OFS_CTRL)) begin
      ctrl_ff <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_ff <= '0;
    end else if (reg_write(OFS_MODE)) begin
      mode_ff <= hwdata[NCH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      evt_en_ff <= '0;
    end else if (reg_write(OFS_EVT_EN)) begin
      evt_en_ff <= hwdata[4*NCH-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_ff <= '0;
    end else if (reg_write(OFS_MASK)) begin
      mask_ff <= hwdata[ST_W-1:0];
    end
  end

  // Write one to clear status
  always_comb begin
    st_clr = '0;
    if (reg_write(OFS_STATUS)) begin
      st_clr = hwdata[ST_W-1:0];
    end
  end

  // Process event delivery: one word held until acknowledged
  assign event_take = rif.event_any & ctrl_ff[CTRL_PROC_EN];
  assign slot_free  = ~status_ff[ST_PROC] | st_clr[ST_PROC];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      event_data_ff <= '0;
    end else if (event_take && slot_free) begin
      event_data_ff <= rif.event_word;
    end
  end

  // New diagnostic fault raises the diagnostic interrupt
  assign diag_hit = ctrl_ff[CTRL_DIAG_EN] & (|(rif.record & ~prev_rec_ff));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prev_rec_ff <= '0;
    end else begin
      prev_rec_ff <= rif.record;
    end
  end

  // Record snapshot taken when the diagnostic interrupt fires
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      snap_rec_ff <= '0;
    end else if (diag_hit) begin
      snap_rec_ff <= rif.record;
    end
  end

  // Status sets win over same-cycle clears
  always_comb begin
    st_set          = '0;
    st_set[ST_PROC] = event_take & slot_free;
    st_set[ST_LOST] = event_take & ~slot_free;
    st_set[ST_DIAG] = diag_hit;
    nxt_status      = (status_ff & ~st_clr) | st_set;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_ff <= STATUS_RST;
    end else begin
      status_ff <= nxt_status;
    end
  end

  // Read mux sampled in the address phase
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    if (rd_addr == OFS_CTRL) begin
      nxt_rdata[1:0] = ctrl_ff;
    end else if (rd_addr == OFS_MODE) begin
      nxt_rdata[NCH-1:0] = mode_ff;
    end else if (rd_addr == OFS_EVT_EN) begin
      nxt_rdata[4*NCH-1:0] = evt_en_ff;
    end else if (rd_addr == OFS_EVT_DATA) begin
      nxt_rdata = event_data_ff;
    end else if (rd_addr == OFS_GROUP) begin
      nxt_rdata = rif.record[31:0];
    end else if (rd_addr == OFS_STATUS) begin
      nxt_rdata[ST_W-1:0] = status_ff;
    end else if (rd_addr == OFS_MASK) begin
      nxt_rdata[ST_W-1:0] = mask_ff;
    end else if (rd_addr >= OFS_REC_BASE && rd_addr <= OFS_REC_LAST && rd_addr[1:0] == 2'h0) begin
      nxt_rdata = snap_rec_ff[32*rd_addr[3:2] +: 32];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= '0;
    end else if (addr_valid && !hwrite) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // Bus answer: zero wait, always OKAY
  assign hreadyout   = 1'b1;
  assign hresp       = HRESP_OKAY;
  assign hrdata      = hrdata_ff;

  // Interrupt outputs
  assign process_irq = status_ff[ST_PROC] & mask_ff[ST_PROC];
  assign diag_irq    = |(status_ff[ST_LOST:ST_DIAG] & mask_ff[ST_LOST:ST_DIAG]);
  assign irq         = |(status_ff & mask_ff);
endmodule : counter_interrupt_reporting
`default_nettype wire

// File: testbench/report_properties.sv
// Checker for bus and interrupt outputs of the reporting block
`timescale 1ns/1ps
`default_nettype none
module report_properties
  import report_pkg::*;
(
  input wire logic        hclk, hresetn, hsel, hwrite, hready, hreadyout,
  input wire logic        irq, process_irq, diag_irq,
  input wire logic [1:0]  htrans, hresp,
  input wire logic [31:0] hrdata,
  input wire logic [7:0]  gate_open, gate_close, count_wrap, compare_hit,
  input wire logic [7:0]  measure_done, limit_exceeded, channel_error,
  input wire logic        module_failed_flag, internal_error, external_error_flag,
  input wire logic        params_missing, params_incorrect, watchdog_trip_flag,
  input wire logic [15:0] single_error
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic wr_dp_ff;
  wire logic ev_any = |{gate_open, gate_close, count_wrap, compare_hit, measure_done,
                        limit_exceeded};
  wire logic flt_any = |{module_failed_flag, internal_error, external_error_flag,
                         params_missing, params_incorrect, watchdog_trip_flag,
                         channel_error, single_error};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_dp_ff <= 1'b0;
    end else begin
      wr_dp_ff <= hsel && htrans[1] && hready && hwrite;
    end
  end
  AST_OKAY: assert property (hresp == HRESP_OKAY) else $error("bad response");
  AST_READY: assert property (hreadyout) else $error("wait state");
  AST_IRQ_SUM: assert property (irq == (process_irq || diag_irq))
    else $error("irq not sum");
  AST_PROC_RISE: assert property ($rose(process_irq) |-> $past(ev_any) || $past(wr_dp_ff))
    else $error("process irq uncaused");
  AST_DIAG_RISE: assert property ($rose(diag_irq) |->
    $past(ev_any) || $past(ev_any, 2) || $past(flt_any) || $past(wr_dp_ff))
    else $error("diag irq uncaused");
  AST_PROC_FALL: assert property ($fell(process_irq) |-> $past(wr_dp_ff))
    else $error("process irq dropped");
  AST_DIAG_FALL: assert property ($fell(diag_irq) |-> $past(wr_dp_ff))
    else $error("diag irq dropped");
  AST_RDATA_HOLD: assert property (!$stable(hrdata) |->
    $past(hsel && htrans[1] && hready && !hwrite)) else $error("read data moved");
  cover property ($rose(process_irq));
  cover property ($rose(diag_irq));
  cover property (irq && !process_irq);
endmodule : report_properties
bind counter_interrupt_reporting report_properties chk (.*);
`default_nettype wire

// File: testbench/host_master.sv
// Host bus master issuing single word transfers
`timescale 1ns/1ps
`default_nettype none
module host_master (
  input  wire logic        hclk,
  input  wire logic        hreadyout,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 64);
    if (hreadyout !== 1'b1) begin
      counter_interrupt_reporting_bench.stall_out();
    end
  endtask : wait_ready
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_ready;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready;
    q = hrdata;
  endtask : xfer
endmodule : host_master
`default_nettype wire

// File: testbench/counter_interrupt_reporting_bench.sv
// Self-checking bench for the counter reporting block
`timescale 1ns/1ps
`default_nettype none
module counter_interrupt_reporting_bench;
  import report_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, irq, process_irq, diag_irq;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [7:0]  ev [6];
  logic [5:0]  fl;
  logic [7:0]  ce;
  logic [15:0] se;
  int          n_fail;
  int          total_checks;
  host_master host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  counter_interrupt_reporting dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .irq(irq),
    .process_irq(process_irq), .diag_irq(diag_irq), .gate_open(ev[0]), .gate_close(ev[1]),
    .count_wrap(ev[2]), .compare_hit(ev[3]), .measure_done(ev[4]), .limit_exceeded(ev[5]),
    .module_failed_flag(fl[0]), .internal_error(fl[1]), .external_error_flag(fl[2]),
    .params_missing(fl[3]), .params_incorrect(fl[4]), .watchdog_trip_flag(fl[5]),
    .channel_error(ce), .single_error(se));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    if (n_fail == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict
  task automatic stall_out;
    n_fail++;
    give_verdict;
  endtask : stall_out
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    check(q, e);
  endtask : rd
  function automatic logic [127:0] rec;
    logic [127:0] r;
    r = 128'h0;
    r[2:0] = fl[2:0];
    r[3] = |ce;
    r[7:6] = fl[4:3];
    r[19] = fl[5];
    r[63:56] = ce;
    for (int n = 0; n < 8; n++) begin
      r[68 + 8*n] = se[2*n];
      r[70 + 8*n] = se[2*n+1];
    end
    return r;
  endfunction : rec
  task automatic pulse(input int k, input int ch);
    ev[k][ch] <= 1'b1;
    @(posedge hclk);
    ev[k][ch] <= 1'b0;
    @(posedge hclk);
  endtask : pulse
  task automatic t_reset;
    for (int a = 0; a <= 'h30; a += 4) begin
      rd(a[11:0], 32'h0);
    end
    host.hsize <= 3'h0;
    wr(OFS_MASK, 32'hFFFFFFFF);
    host.hsize <= 3'h2;
    rd(OFS_MASK, 32'h0);
    wr(12'h030, 32'hFFFFFFFF);
    rd(12'h030, 32'h0);
  endtask : t_reset
  task automatic t_events(input logic fm);
    wr(OFS_MODE, {24'h0, {8{fm}}});
    for (int ch = 0; ch < 8; ch++) begin
      for (int k = 0; k < 4; k++) begin
        pulse((k < 2 || !fm) ? k : k + 2, ch);
        check({31'h0, process_irq}, 32'h1);
        rd(OFS_EVT_DATA, 32'h1 << (4*ch + k));
        wr(OFS_STATUS, 32'h1);
      end
    end
    pulse(fm ? 2 : 4, 0);
    check({31'h0, process_irq}, 32'h0);
  endtask : t_events
  task automatic t_lost;
    wr(OFS_MODE, 32'h0);
    pulse(0, 2);
    pulse(1, 5);
    rd(OFS_STATUS, 32'h5);
    rd(OFS_EVT_DATA, 32'h100);
    rd(OFS_GROUP, 32'h40000000);
    check({31'h0, diag_irq}, 32'h1);
    wr(OFS_MASK, 32'h0);
    @(posedge hclk);
    check({31'h0, irq}, 32'h0);
    wr(OFS_MASK, 32'h7);
    wr(OFS_STATUS, 32'h7);
    rd(OFS_STATUS, 32'h0);
  endtask : t_lost
  task automatic t_order;
    pulse(0, 2);
    fork
      wr(OFS_STATUS, 32'h1);
      begin
        @(posedge hclk);
        ev[1][3] <= 1'b1;
        @(posedge hclk);
        ev[1][3] <= 1'b0;
      end
    join
    rd(OFS_STATUS, 32'h1);
    rd(OFS_EVT_DATA, 32'h2000);
    wr(OFS_STATUS, 32'h1);
    wr(OFS_EVT_EN, 32'hFFFFFFFE);
    pulse(0, 0);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_EVT_EN, 32'hFFFFFFFF);
    wr(OFS_CTRL, 32'h0);
    pulse(0, 0);
    rd(OFS_STATUS, 32'h0);
  endtask : t_order
  task automatic t_diag(input logic [5:0] f, input logic [7:0] c, input logic [15:0] s);
    logic [127:0] r;
    fl <= f;
    ce <= c;
    se <= s;
    @(posedge hclk);
    @(posedge hclk);
    r = rec();
    check({31'h0, diag_irq}, 32'h1);
    rd(OFS_GROUP, r[31:0]);
    for (int i = 0; i < 4; i++) begin
      rd(OFS_REC_BASE + 12'(4*i), r[32*i +: 32]);
    end
    wr(OFS_STATUS, 32'h2);
  endtask : t_diag
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    ev = '{default: 8'h0};
    fl = 6'h0;
    ce = 8'h0;
    se = 16'h0;
    n_fail = 0;
    total_checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    wr(OFS_CTRL, 32'h1);
    wr(OFS_EVT_EN, 32'hFFFFFFFF);
    wr(OFS_MASK, 32'h7);
    t_events(1'b0);
    t_events(1'b1);
    t_lost;
    t_order;
    wr(OFS_CTRL, 32'h3);
    for (int i = 0; i < 6; i++) begin
      t_diag(fl | (6'h1 << i), 8'h0, 16'h0);
    end
    t_diag(fl, 8'h24, 16'h0);
    t_diag(fl, ce, 16'h8001);
    give_verdict;
  end
endmodule : counter_interrupt_reporting_bench
`default_nettype wire
